// file: design/adc_serial_readout.sv
`timescale 1ns/1ps
// Serial readout and power sequencing of the converter
module adc_serial_readout #(
    parameter int RES_BITS = 12,
    parameter int FIFO_DEPTH = 8
) (
    input wire logic mclk, // 200 MHz system clock
    input wire logic rst_b, // Async reset, active low
    input wire logic sel_b, // Host select pin, active low
    input wire logic sclk, // Host serial clock pin
    input wire logic res_valid, // Converter core offers a result
    output logic res_ready, // FIFO can take a result
    input wire logic [RES_BITS-1:0] res_data, // Result from converter core
    output logic result_serial_out, // Serial data out
    output logic result_serial_oe, // Output enable, high while driving
    output logic powered_up, // Wake-up in progress or running
    output logic full_power, // All blocks fully enabled
    output logic sampling, // Sample window open
    output logic converting, // Conversion interval
    output logic abort_flag // Last frame aborted; next result invalid
);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic sel_m_r, sel_s_r, sel_d_r, sclk_m_r, sclk_s_r, sclk_d_r;
    logic sel_fall, sel_rise, sclk_fall;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sel_m_r <= 1'b1;
            sel_s_r <= 1'b1;
            sel_d_r <= 1'b1;
            sclk_m_r <= 1'b0;
            sclk_s_r <= 1'b0;
            sclk_d_r <= 1'b0;
        end else begin
            sel_m_r <= sel_b;
            sel_s_r <= sel_m_r;
            sel_d_r <= sel_s_r;
            sclk_m_r <= sclk;
            sclk_s_r <= sclk_m_r;
            sclk_d_r <= sclk_s_r;
        end
    end

    assign sel_fall = sel_d_r && !sel_s_r;
    assign sel_rise = !sel_d_r && sel_s_r;
    assign sclk_fall = sclk_d_r && !sclk_s_r && !sel_s_r;

    // ----------------------------------------
    // Result buffer
    // ----------------------------------------
    logic fifo_valid, fifo_take;
    logic [RES_BITS-1:0] fifo_data;

    sample_fifo #(.WIDTH(RES_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
        .mclk(mclk),
        .rst_b(rst_b),
        .in_valid(res_valid),
        .in_ready(res_ready),
        .in_data(res_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_take),
        .out_data(fifo_data)
    );

    // ----------------------------------------
    // Frame sequencer
    // ----------------------------------------
    adc_serial_pkg::adc_state_t st_r, st_nxt;
    logic [4:0] edge_r, edge_nxt;
    logic [RES_BITS-1:0] shift_r, shift_nxt;
    logic dout_r, dout_nxt, oe_r, oe_nxt, abort_r, abort_nxt, full_r, full_nxt;

    // Sample or convert: the block is awake
    function automatic logic active_st(input adc_serial_pkg::adc_state_t s);
        return (s == adc_serial_pkg::ST_SAMPLE) || (s == adc_serial_pkg::ST_CONVERT);
    endfunction

    always_comb begin
        st_nxt = st_r;
        edge_nxt = edge_r;
        shift_nxt = shift_r;
        dout_nxt = dout_r;
        oe_nxt = oe_r;
        abort_nxt = abort_r;
        full_nxt = full_r;
        fifo_take = 1'b0;
        if (sel_rise) begin
            if (active_st(st_r) && edge_r < adc_serial_pkg::ABORT_EDGES) begin
                abort_nxt = 1'b1;
            end
            st_nxt = adc_serial_pkg::ST_DOWN;
            oe_nxt = 1'b0;
            full_nxt = 1'b0;
            edge_nxt = adc_serial_pkg::CNT_RST;
        end else if (sel_fall && st_r == adc_serial_pkg::ST_DOWN) begin
            st_nxt = adc_serial_pkg::ST_SAMPLE;
            edge_nxt = adc_serial_pkg::CNT_RST;
            oe_nxt = 1'b1;
            dout_nxt = 1'b0;
        end else if (sclk_fall && st_r != adc_serial_pkg::ST_DOWN && st_r != adc_serial_pkg::ST_DONE) begin
            edge_nxt = 5'(edge_r + 5'h01);
            if (edge_nxt == adc_serial_pkg::WAKE_EDGE) begin
                st_nxt = adc_serial_pkg::ST_CONVERT;
                full_nxt = 1'b1;
                shift_nxt = fifo_valid ? fifo_data : adc_serial_pkg::RESULT_RST;
                fifo_take = fifo_valid;
                abort_nxt = 1'b0;
            end
            if (edge_nxt < adc_serial_pkg::LEAD_ZEROS) begin
                dout_nxt = 1'b0;
            end else if (edge_nxt == adc_serial_pkg::WAKE_EDGE) begin
                dout_nxt = fifo_valid ? fifo_data[RES_BITS-1] : 1'b0;
            end else if (edge_nxt < adc_serial_pkg::LAST_EDGE) begin
                dout_nxt = shift_r[RES_BITS-2];
                shift_nxt = {shift_r[RES_BITS-2:0], 1'b0};
            end
            if (edge_nxt == adc_serial_pkg::LAST_EDGE) begin
                oe_nxt = 1'b0;
                full_nxt = 1'b0;
                st_nxt = adc_serial_pkg::ST_DONE;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= adc_serial_pkg::ST_DOWN;
            edge_r <= adc_serial_pkg::CNT_RST;
            shift_r <= adc_serial_pkg::RESULT_RST;
            dout_r <= 1'b0;
            oe_r <= 1'b0;
            abort_r <= 1'b0;
            full_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            edge_r <= edge_nxt;
            shift_r <= shift_nxt;
            dout_r <= dout_nxt;
            oe_r <= oe_nxt;
            abort_r <= abort_nxt;
            full_r <= full_nxt;
        end
    end

    assign result_serial_out = dout_r;
    assign result_serial_oe = oe_r;
    assign powered_up = active_st(st_r);
    assign full_power = full_r;
    assign sampling = (st_r == adc_serial_pkg::ST_SAMPLE);
    assign converting = (st_r == adc_serial_pkg::ST_CONVERT);
    assign abort_flag = abort_r;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_sixteenth;
        sclk_fall && st_r == adc_serial_pkg::ST_CONVERT && edge_r == 5'h0F;
    endsequence

    float_at_end_a: assert property (@(posedge mclk) disable iff (!rst_b)
        s_sixteenth |=> !result_serial_oe) else $error("Output not floated at last edge");
    power_down_a: assert property (@(posedge mclk) disable iff (!rst_b)
        s_sixteenth |=> st_r == adc_serial_pkg::ST_DONE && !full_power) else $error("No power-down after frame");
    float_idle_a: assert property (@(posedge mclk) disable iff (!rst_b)
        sel_rise |=> !result_serial_oe) else $error("Output driven with select high");
    wake_start_a: assert property (@(posedge mclk) disable iff (!rst_b)
        sel_fall && st_r == adc_serial_pkg::ST_DOWN && !sel_rise |=> sampling) else $error("No wake on select");
    full_on_a: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(full_power) |-> edge_r == adc_serial_pkg::WAKE_EDGE && converting) else $error("Early full power");
    lead_zero_a: assert property (@(posedge mclk) disable iff (!rst_b)
        result_serial_oe && edge_r < adc_serial_pkg::LEAD_ZEROS |-> !result_serial_out) else $error("Lead bit not 0");
    abort_early_a: assert property (@(posedge mclk) disable iff (!rst_b)
        sel_rise && powered_up && edge_r < 5'h0A |=> abort_flag && st_r == adc_serial_pkg::ST_DOWN)
        else $error("Early deselect not aborted");
    edge_only_a: assert property (@(posedge mclk) disable iff (!rst_b)
        !sclk_fall && !sel_rise && !sel_fall |=> $stable(edge_r)) else $error("Count moved without edge");
    msb_first_a: assert property (@(posedge mclk) disable iff (!rst_b)
        converting && sclk_fall && edge_r > 5'h02 && edge_r < 5'h0F |=> result_serial_out == $past(shift_r[10]))
        else $error("Bit order wrong");

    // ----------------------------------------
    // Frame step checks
    // ----------------------------------------
    // Antecedents of the checks below, the first two shared by several
    sequence s_wake;
        sel_fall && st_r == adc_serial_pkg::ST_DOWN && !sel_rise;
    endsequence

    sequence s_third_edge;
        sclk_fall && sampling && edge_r == 5'h02 && !sel_rise;
    endsequence

    sequence s_late_deselect;
        sel_rise && converting && edge_r >= adc_serial_pkg::ABORT_EDGES;
    endsequence

    wake_drive_a: assert property (@(posedge mclk) disable iff (!rst_b)
        s_wake |=>
        result_serial_oe && !result_serial_out && edge_r == adc_serial_pkg::CNT_RST)
        else $error("First lead zero missing");

    wake_quiet_a: assert property (@(posedge mclk) disable iff (!rst_b)
        s_wake |=>
        !full_power && !converting)
        else $error("Full power at wake");

    wake_edge_a: assert property (@(posedge mclk) disable iff (!rst_b)
        s_third_edge |=>
        converting && full_power && edge_r == adc_serial_pkg::WAKE_EDGE)
        else $error("Sample window not closed at third edge");

    abort_clear_a: assert property (@(posedge mclk) disable iff (!rst_b)
        s_third_edge |=>
        !abort_flag)
        else $error("Abort mark not cleared");

    fifo_pop_a: assert property (@(posedge mclk) disable iff (!rst_b)
        s_third_edge ##0 fifo_valid |->
        fifo_take)
        else $error("Result not taken at third edge");

    msb_at_wake_a: assert property (@(posedge mclk) disable iff (!rst_b)
        s_third_edge ##0 fifo_valid |=>
        result_serial_out == $past(fifo_data[RES_BITS-1]))
        else $error("First result bit not the top bit");

    empty_zero_a: assert property (@(posedge mclk) disable iff (!rst_b)
        s_third_edge ##0 !fifo_valid |=>
        !result_serial_out)
        else $error("Empty buffer gave a nonzero bit");

    late_keep_a: assert property (@(posedge mclk) disable iff (!rst_b)
        s_late_deselect ##0 !abort_flag |=>
        !abort_flag && !powered_up)
        else $error("Late deselect marked as abort");

    sample_span_a: assert property (@(posedge mclk) disable iff (!rst_b)
        sampling |->
        edge_r < adc_serial_pkg::WAKE_EDGE && !full_power)
        else $error("Sample window too long");

    convert_span_a: assert property (@(posedge mclk) disable iff (!rst_b)
        converting |->
        edge_r >= adc_serial_pkg::WAKE_EDGE && edge_r < adc_serial_pkg::LAST_EDGE)
        else $error("Conversion outside its edges");

    full_match_a: assert property (@(posedge mclk) disable iff (!rst_b)
        full_power |->
        converting)
        else $error("Full power outside conversion");

    down_float_a: assert property (@(posedge mclk) disable iff (!rst_b)
        st_r == adc_serial_pkg::ST_DOWN |->
        !result_serial_oe && edge_r == adc_serial_pkg::CNT_RST)
        else $error("Output driven in power-down");

    done_float_a: assert property (@(posedge mclk) disable iff (!rst_b)
        st_r == adc_serial_pkg::ST_DONE |->
        !result_serial_oe && !full_power)
        else $error("Output driven after frame end");

    done_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
        st_r == adc_serial_pkg::ST_DONE && !sel_rise |=>
        st_r == adc_serial_pkg::ST_DONE)
        else $error("Finished frame restarted without deselect");

    edge_step_a: assert property (@(posedge mclk) disable iff (!rst_b)
        sclk_fall && active_st(st_r) && !sel_rise |=>
        edge_r == 5'($past(edge_r) + 5'h01))
        else $error("Edge count did not step");

    bit_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
        result_serial_oe && !sclk_fall && !sel_rise |=>
        $stable(result_serial_out))
        else $error("Output bit moved between falling edges");

    deselect_down_a: assert property (@(posedge mclk) disable iff (!rst_b)
        sel_rise |=>
        !powered_up && !full_power)
        else $error("Still awake after deselect");

    oe_awake_a: assert property (@(posedge mclk) disable iff (!rst_b)
        result_serial_oe |->
        powered_up)
        else $error("Output driven while not awake");

    full_ready_a: assert property (@(posedge mclk) disable iff (!rst_b)
        !res_ready |->
        fifo_valid)
        else $error("Buffer full yet empty");

    sel_gate_a: assert property (@(posedge mclk) disable iff (!rst_b)
        sel_s_r |->
        !sclk_fall)
        else $error("Clock edge seen with select high");

    down_ignore_a: assert property (@(posedge mclk) disable iff (!rst_b)
        sclk_fall && !sel_fall && st_r == adc_serial_pkg::ST_DOWN |=>
        st_r == adc_serial_pkg::ST_DOWN)
        else $error("Clock edge woke the block");

    oe_rise_a: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(result_serial_oe) |->
        sampling && edge_r == adc_serial_pkg::CNT_RST)
        else $error("Output enabled without wake");
endmodule

// file: design/adc_serial_pkg.sv
// Constants for the serial converter readout block
package adc_serial_pkg;
    localparam int unsigned MCLK_MHZ = 200;
    localparam int unsigned QUIET_NS = 1000;
    localparam int unsigned QUIET_CYC = (QUIET_NS * MCLK_MHZ + 999) / 1000;
    localparam logic [4:0] LEAD_ZEROS = 5'h03;
    localparam logic [4:0] WAKE_EDGE = 5'h03;
    localparam logic [4:0] ABORT_EDGES = 5'h0A;
    localparam logic [4:0] LAST_EDGE = 5'h10;
    localparam logic [4:0] CNT_RST = 5'h00;
    localparam logic [11:0] RESULT_RST = 12'h000;

    typedef enum logic [1:0] {
        ST_DOWN = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONVERT = 2'b10,
        ST_DONE = 2'b11
    } adc_state_t;
endpackage

// file: design/sample_fifo.sv
`timescale 1ns/1ps
// Small flip-flop FIFO with valid and ready on both sides
module sample_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    input wire logic mclk, // System clock
    input wire logic rst_b, // Async reset, active low
    input wire logic in_valid, // Write offered
    output logic in_ready, // Space available
    input wire logic [WIDTH-1:0] in_data, // Write word
    output logic out_valid, // Word available
    input wire logic out_ready, // Reader takes word
    output logic [WIDTH-1:0] out_data // Head word
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic wr, rd;

    always_comb begin
        in_ready = (cnt_r != DEPTH[AW:0]);
        out_valid = (cnt_r != '0);
        out_data = mem_r[rp_r];
        wr = in_valid && in_ready;
        rd = out_valid && out_ready;
        wp_nxt = wr ? AW'(wp_r + 1'b1) : wp_r;
        rp_nxt = rd ? AW'(rp_r + 1'b1) : rp_r;
        cnt_nxt = (AW+1)'(cnt_r + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd});
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    always_ff @(posedge mclk) begin
        if (wr) begin
            mem_r[wp_r] <= in_data;
        end
    end
endmodule

// file: verif/host_serial_model.sv
// Behavioural host that frames the converter link
`timescale 1ns/1ps
module host_serial_model (
    output logic sel_b, // Select, active low
    output logic sclk, // Serial clock, idle high
    input wire logic sdo // Serial data from block
);
    logic [14:0] got;
    int n_fall;
    initial begin
        sel_b = 1'b1;
        sclk = 1'b1;
        got = 15'h0000;
        n_fall = 0;
    end
    // ----------------
    // Frame tasks
    // ----------------
    task automatic begin_frame();
        n_fall = 0;
        sel_b = 1'b0;
        #40;
        got = {got[13:0], sdo};
    endtask
    // Clock stands still outside frames
    task automatic pulses(input int n);
        repeat (n) begin
            sclk = 1'b0;
            #40;
            sclk = 1'b1;
            n_fall++;
            if (n_fall < 15)
                got = {got[13:0], sdo};
            #40;
        end
    endtask
    task automatic end_frame();
        sel_b = 1'b1;
        #(adc_serial_pkg::QUIET_NS);
    endtask
endmodule

// file: verif/adc_serial_readout_tb.sv
// Self-checking bench for the serial converter readout
`timescale 1ns/1ps
module adc_serial_readout_tb;
    logic mclk, rst_b, sel_b, sclk, res_valid, res_ready, sdo, sdo_oe;
    logic powered_up, full_power, sampling, converting, abort_flag;
    logic [11:0] res_data;
    int mismatches, n_compared, cyc;
    adc_serial_readout i_dut (.mclk(mclk), .rst_b(rst_b), .sel_b(sel_b), .sclk(sclk),
        .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data),
        .result_serial_out(sdo), .result_serial_oe(sdo_oe), .powered_up(powered_up),
        .full_power(full_power), .sampling(sampling), .converting(converting), .abort_flag(abort_flag));
    host_serial_model i_host (.sel_b(sel_b), .sclk(sclk), .sdo(sdo));
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // ----------------
    // Helpers
    // ----------------
    function automatic logic [11:0] word_of(input int i);
        return 12'h800 ^ 12'(i * 12'h111);
    endfunction
    task automatic check(input string name, input logic [14:0] seen, input logic [14:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("mismatches %0d n_compared %0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Timeout well above the expected run of about 5400 cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            final_report();
        end
    end
    // ----------------
    // Scenarios
    // ----------------
    task automatic push(input logic [11:0] w);
        @(posedge mclk);
        #1 res_valid = 1'b1;
        res_data = w;
        do @(posedge mclk); while (res_ready !== 1'b1);
        #1 res_valid = 1'b0;
    endtask
    task automatic fill_fifo();
        for (int i = 0; i < 8; i++)
            push(word_of(i));
        @(posedge mclk);
        #1 res_valid = 1'b1;
        res_data = 12'hFFF;
        repeat (4) @(posedge mclk);
        #1 check("res_ready full", res_ready, 15'h0000);
        res_valid = 1'b0;
    endtask
    task automatic full_frame(input logic [11:0] w, input logic prev_abort);
        i_host.begin_frame();
        check("oe at select", sdo_oe, 15'h0001);
        check("powered_up", powered_up, 15'h0001);
        i_host.pulses(2);
        check("full_power early", full_power, 15'h0000);
        check("sampling", sampling, 15'h0001);
        check("abort kept", abort_flag, 15'(prev_abort));
        i_host.pulses(1);
        check("full_power", full_power, 15'h0001);
        check("converting", converting, 15'h0001);
        check("abort cleared", abort_flag, 15'h0000);
        i_host.pulses(13);
        check("oe after last", sdo_oe, 15'h0000);
        check("full_power end", full_power, 15'h0000);
        check("bits", i_host.got, {3'b000, w});
        i_host.end_frame();
        check("powered down", powered_up, 15'h0000);
        check("oe idle", sdo_oe, 15'h0000);
    endtask
    task automatic short_frame(input int n, input logic exp_flag);
        i_host.begin_frame();
        i_host.pulses(n);
        i_host.end_frame();
        check("abort_flag", abort_flag, 15'(exp_flag));
        check("oe released", sdo_oe, 15'h0000);
        check("powered_up", powered_up, 15'h0000);
    endtask
    initial begin
        rst_b = 1'b0;
        res_valid = 1'b0;
        res_data = 12'h000;
        mismatches = 0;
        n_compared = 0;
        cyc = 0;
        repeat (20) @(posedge mclk);
        #1 rst_b = 1'b1;
        check("oe after reset", sdo_oe, 15'h0000);
        fill_fifo();
        for (int i = 0; i < 8; i++)
            full_frame(word_of(i), 1'b0);
        // Empty FIFO reads back as zero
        full_frame(12'h000, 1'b0);
        short_frame(9, 1'b1);
        full_frame(12'h000, 1'b1);
        short_frame(10, 1'b0);
        final_report();
    end
endmodule
